// ### logic/cmp_defines.svh
// register offsets, field positions and reset values of the comparator pair
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH

// address window and register offsets (byte addresses)
`define CMP_ADDR_W 12
`define CMP_CTRL_OFFSET 12'h000
`define CMP_STAT_OFFSET 12'h004

// control word fields
`define CMP_FIRST_EN_BIT 0
`define CMP_FIRST_SEL_HI 2
`define CMP_FIRST_SEL_LO 1
`define CMP_SECOND_EN_BIT 4
`define CMP_SECOND_SEL_HI 6
`define CMP_SECOND_SEL_LO 5
`define CMP_CTRL_WR_MASK 32'h0000_0077
`define CMP_CTRL_RESET 32'h0000_0000

// status word fields
`define CMP_FIRST_RESULT_BIT 0
`define CMP_SECOND_RESULT_BIT 1
`define CMP_ZERO_WORD 32'h0000_0000

// reference selector codes
`define CMP_SEL_VREF 2'h0
`define CMP_SEL_PIN 2'h1
`define CMP_SEL_CONV0 2'h2
`define CMP_SEL_CONV1 2'h3

`endif

// ### logic/cmp_pkg.sv
// types shared by the comparator pair
`default_nettype none
`include "cmp_defines.svh"

package cmp_pkg;
  // source routed to a comparator's negative input
  typedef enum logic [1:0] {
    SRC_VREF = `CMP_SEL_VREF,
    SRC_PIN = `CMP_SEL_PIN,
    SRC_CONV0 = `CMP_SEL_CONV0,
    SRC_CONV1 = `CMP_SEL_CONV1
  } ref_sel_t;
endpackage : cmp_pkg

`default_nettype wire

// ### logic/cmp_ch_if.sv
// settings and result travelling between the top and one comparator
`default_nettype none

interface cmp_ch_if;
  logic enable;
  cmp_pkg::ref_sel_t select;
  logic result;
  // register side drives settings, channel returns its result
  modport top (output enable, output select, input result);
  modport chan (input enable, input select, output result);
endinterface : cmp_ch_if

`default_nettype wire

// ### logic/bit_sync.sv
// two-stage synchroniser for a group of pin levels
`default_nettype none

module bit_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels in and out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // the first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : bit_sync

`default_nettype wire

// ### logic/compare_channel.sv
// one comparator: input capture, reference routing, compare and gating
`default_nettype none
`include "cmp_defines.svh"

module compare_channel #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // settings from the control word, result back
  cmp_ch_if.chan ch,
  // sampled analog levels as codes, straight from the pins
  input wire logic [W-1:0] pos_raw,
  input wire logic [W-1:0] alt_raw,
  input wire logic [W-1:0] conv0_raw,
  input wire logic [W-1:0] conv1_raw,
  input wire logic [W-1:0] vref_raw,
  // shutdown request to the analog core
  output logic power_down
);
  import cmp_pkg::*;

  logic [5*W-1:0] raw_s;
  logic [W-1:0] pos_s;
  logic [W-1:0] alt_s;
  logic [W-1:0] conv0_s;
  logic [W-1:0] conv1_s;
  logic [W-1:0] vref_s;
  logic [W-1:0] ref_s;
  logic result_ff;

  // all five levels come from outside the clock domain
  bit_sync #(.W(5*W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({pos_raw, alt_raw, conv0_raw, conv1_raw, vref_raw}),
    .sync_out(raw_s)
  );
  assign {pos_s, alt_s, conv0_s, conv1_s, vref_s} = raw_s;

  // four-way negative input routing
  function automatic logic [W-1:0] pick_ref(input ref_sel_t sel,
    input logic [W-1:0] vref, input logic [W-1:0] pin,
    input logic [W-1:0] c0, input logic [W-1:0] c1);
    unique case (sel)
      SRC_VREF: pick_ref = vref;
      SRC_PIN: pick_ref = pin;
      SRC_CONV0: pick_ref = c0;
      SRC_CONV1: pick_ref = c1;
    endcase
  endfunction : pick_ref

  assign ref_s = pick_ref(ch.select, vref_s, alt_s, conv0_s, conv1_s);

  // strictly greater gives one; a stopped comparator reads zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_ff <= 1'b0;
    else
      result_ff <= ch.enable & (pos_s > ref_s);
  end

  assign ch.result = result_ff;
  assign power_down = ~ch.enable;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  compare_result_a: assert property (
    ##1 ch.result == $past(ch.enable && (pos_s > ref_s)))
    else $error("comparator result does not follow its inputs");
endmodule : compare_channel

`default_nettype wire

// ### logic/dual_comparator_control.sv
// control word, result readback and apb slave for two comparators
`default_nettype none
`include "cmp_defines.svh"

module dual_comparator_control #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CMP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // first comparator levels
  input wire logic [W-1:0] first_positive_input,
  input wire logic [W-1:0] first_alternate_reference_pin,
  // second comparator levels
  input wire logic [W-1:0] second_positive_input,
  input wire logic [W-1:0] second_alternate_reference_pin,
  // shared references
  input wire logic [W-1:0] converter_zero_output,
  input wire logic [W-1:0] converter_one_output,
  input wire logic [W-1:0] reference_voltage,
  // results and shutdown controls
  output logic first_compare_result,
  output logic second_compare_result,
  output logic first_power_down,
  output logic second_power_down
);
  import cmp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic [31:0] ctrl_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic setup_phase;
  logic access_phase;
  logic hit_ctrl;
  logic hit_stat;
  logic wr_ctrl;
  logic [31:0] stat_word;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;

  cmp_ch_if ch0 ();
  cmp_ch_if ch1 ();

  //////////////////////////////////////////////////////////////////////////
  // address decode

  // only two words live in the window, everything else errors
  function automatic logic is_offset(input logic [`CMP_ADDR_W-1:0] a,
    input logic [`CMP_ADDR_W-1:0] off);
    is_offset = (a == off);
  endfunction : is_offset

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  // the whole window is decoded, so aliases of the two words error
  assign hit_ctrl = is_offset(paddr, `CMP_CTRL_OFFSET);
  assign hit_stat = is_offset(paddr, `CMP_STAT_OFFSET);

  // no wait states: every access completes in its first access cycle
  // a tie-off is safe: every answer is registered at the end of setup, so it is ready from the first access cycle on
  assign pready = 1'b1;
  assign wr_ctrl = access_phase & pwrite & hit_ctrl;

  //////////////////////////////////////////////////////////////////////////
  // shared control word

  // one word holds both channels; reserved bits never store
  // the mask makes reserved bits read zero with no extra read logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= `CMP_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_ff <= pwdata & `CMP_CTRL_WR_MASK;
  end

  // settings out to the two channels
  // the select cast is safe: all four codes of the field are legal
  assign ch0.enable = ctrl_ff[`CMP_FIRST_EN_BIT];
  assign ch0.select = ref_sel_t'(
    ctrl_ff[`CMP_FIRST_SEL_HI:`CMP_FIRST_SEL_LO]);
  assign ch1.enable = ctrl_ff[`CMP_SECOND_EN_BIT];
  assign ch1.select = ref_sel_t'(
    ctrl_ff[`CMP_SECOND_SEL_HI:`CMP_SECOND_SEL_LO]);

  //////////////////////////////////////////////////////////////////////////
  // comparator channels

  // both channels see the same converter and reference levels
  compare_channel #(.W(W)) u_first (
    .pclk(pclk),
    .presetn(presetn),
    .ch(ch0.chan),
    .pos_raw(first_positive_input),
    .alt_raw(first_alternate_reference_pin),
    .conv0_raw(converter_zero_output),
    .conv1_raw(converter_one_output),
    .vref_raw(reference_voltage),
    .power_down(first_power_down)
  );

  compare_channel #(.W(W)) u_second (
    .pclk(pclk),
    .presetn(presetn),
    .ch(ch1.chan),
    .pos_raw(second_positive_input),
    .alt_raw(second_alternate_reference_pin),
    .conv0_raw(converter_zero_output),
    .conv1_raw(converter_one_output),
    .vref_raw(reference_voltage),
    .power_down(second_power_down)
  );

  assign first_compare_result = ch0.result;
  assign second_compare_result = ch1.result;

  //////////////////////////////////////////////////////////////////////////
  // read path

  // live results, no latching, so a poll always sees the present state
  // the status word is rebuilt every cycle from the two result flops
  always_comb
  begin
    stat_word = `CMP_ZERO_WORD;
    stat_word[`CMP_FIRST_RESULT_BIT] = ch0.result;
    stat_word[`CMP_SECOND_RESULT_BIT] = ch1.result;
  end

  // read data is chosen during setup so it leaves a flop in access
  always_comb
  begin
    nxt_prdata = `CMP_ZERO_WORD;
    nxt_pslverr = 1'b0;
    if (hit_ctrl)
      nxt_prdata = ctrl_ff;
    else if (hit_stat)
      nxt_prdata = pwrite ? `CMP_ZERO_WORD : stat_word;
    else
      nxt_pslverr = 1'b1;
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= `CMP_ZERO_WORD;
    else if (setup_phase)
      prdata_ff <= nxt_prdata;
  end

  // error flag register, cleared whenever no transfer is pending
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr_ff <= 1'b0;
    else if (setup_phase)
      pslverr_ff <= nxt_pslverr;
    else if (!psel)
      pslverr_ff <= 1'b0;
  end

  // writes to the status word are dropped without error
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff & access_phase;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb steps from which the bus checks are built
  sequence setup_s(logic [`CMP_ADDR_W-1:0] off, logic wr);
    psel && !penable && paddr == off && pwrite == wr;
  endsequence

  sequence access_s;
    psel && penable && pready;
  endsequence

  sequence ctrl_write_s;
    setup_s(`CMP_CTRL_OFFSET, 1'b1) ##1 access_s;
  endsequence

  sequence stat_read_s;
    setup_s(`CMP_STAT_OFFSET, 1'b0) ##1 access_s;
  endsequence

  sequence ctrl_read_s;
    setup_s(`CMP_CTRL_OFFSET, 1'b0) ##1 access_s;
  endsequence

  sequence stat_write_s;
    setup_s(`CMP_STAT_OFFSET, 1'b1) ##1 access_s;
  endsequence

  // register side checks
  ctrl_reserved_a: assert property (
    (ctrl_ff & ~`CMP_CTRL_WR_MASK) == `CMP_ZERO_WORD)
    else $error("reserved control bits hold a one");

  ctrl_write_a: assert property (
    ctrl_write_s |=> ctrl_ff == ($past(pwdata) & `CMP_CTRL_WR_MASK))
    else $error("control write did not land masked");

  first_select_a: assert property (
    ctrl_write_s |=> ch0.select == $past(
      pwdata[`CMP_FIRST_SEL_HI:`CMP_FIRST_SEL_LO]))
    else $error("first reference select not taken from bits 2:1");

  second_select_a: assert property (
    ctrl_write_s |=> ch1.select == $past(
      pwdata[`CMP_SECOND_SEL_HI:`CMP_SECOND_SEL_LO]))
    else $error("second reference select not taken from bits 6:5");

  first_off_a: assert property (
    ctrl_write_s ##0 !pwdata[`CMP_FIRST_EN_BIT]
      |=> first_power_down ##1 !first_compare_result [*2])
    else $error("first comparator not stopped by clearing bit 0");

  second_off_a: assert property (
    ctrl_write_s ##0 !pwdata[`CMP_SECOND_EN_BIT]
      |=> second_power_down ##1 !second_compare_result [*2])
    else $error("second comparator not stopped by clearing bit 4");

  status_read_a: assert property (
    stat_read_s |-> prdata[`CMP_FIRST_RESULT_BIT] == $past(ch0.result)
      && prdata[`CMP_SECOND_RESULT_BIT] == $past(ch1.result)
      && prdata[31:2] == '0)
    else $error("status read does not show the live results");

  unmapped_a: assert property (
    psel && !penable && !hit_ctrl && !hit_stat
      |=> (psel && penable) |-> pslverr)
    else $error("unmapped access answered without error");

  mapped_ok_a: assert property (
    psel && !penable && (hit_ctrl || hit_stat)
      |=> !pslverr)
    else $error("mapped access answered with error");

  // a stopped channel must read zero from the cycle after its enable drops
  first_gate_a: assert property (
    !ch0.enable |=> !first_compare_result)
    else $error("first result not forced low while disabled");

  second_gate_a: assert property (
    !ch1.enable |=> !second_compare_result)
    else $error("second result not forced low while disabled");

  first_wake_a: assert property (
    ctrl_write_s ##0 pwdata[`CMP_FIRST_EN_BIT] |=> !first_power_down)
    else $error("first comparator not powered up by setting bit 0");

  second_wake_a: assert property (
    ctrl_write_s ##0 pwdata[`CMP_SECOND_EN_BIT] |=> !second_power_down)
    else $error("second comparator not powered up by setting bit 4");

  // only a control write may move the control word
  ctrl_hold_a: assert property (
    !(psel && penable && pwrite && paddr == `CMP_CTRL_OFFSET)
      |=> $stable(ctrl_ff))
    else $error("control word changed without a control write");

  ctrl_read_a: assert property (
    ctrl_read_s |-> prdata == $past(ctrl_ff))
    else $error("control read does not return the stored word");

  stat_write_a: assert property (
    stat_write_s |-> !pslverr ##1 $stable(ctrl_ff))
    else $error("status write errored or disturbed the control word");

  unmapped_zero_a: assert property (
    psel && penable && !hit_ctrl && !hit_stat |-> prdata == `CMP_ZERO_WORD)
    else $error("unmapped access returned nonzero data");

  idle_error_a: assert property (
    !psel |-> !pslverr)
    else $error("error flag raised outside a transfer");
endmodule : dual_comparator_control

`default_nettype wire

// ### dv/level_sources.sv
// level sources standing in for the analog front end of both comparators
`default_nettype none

module level_sources #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // wanted levels: pos0, alt0, pos1, alt1, conv0, conv1, vref
  input wire logic [6:0][W-1:0] req,
  // levels at the pins
  output logic [6:0][W-1:0] lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // sources move only at a clock edge, so no level glitches mid-cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lvl <= '0;
    else
      lvl <= req;
  end
endmodule : level_sources

`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the comparator pair control block
`default_nettype none
`include "cmp_defines.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cmp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [`CMP_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [6:0][11:0] req, lvl;
  logic r0, r1, pd0, pd1;
  int fail_count, n_checks, cyc;

  ////////////////////////////////////////////////////////////////////////////
  level_sources #(.W(12)) src (.pclk(pclk), .presetn(presetn),
    .req(req), .lvl(lvl));
  dual_comparator_control #(.W(12)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_positive_input(lvl[0]), .first_alternate_reference_pin(lvl[1]),
    .second_positive_input(lvl[2]), .second_alternate_reference_pin(lvl[3]),
    .converter_zero_output(lvl[4]), .converter_one_output(lvl[5]),
    .reference_voltage(lvl[6]), .first_compare_result(r0),
    .second_compare_result(r1), .first_power_down(pd0),
    .second_power_down(pd1));

  ////////////////////////////////////////////////////////////////////////////
  // clock of 100 ns and a bounded run
  initial
  begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic chk32(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk32

  task automatic chk1(input logic g, input logic x);
    n_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk1

  // one apb transfer; read data and error are taken at the pready edge
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : bus

  // expected result worked out from the levels and the selector
  function automatic logic want(input logic [1:0] s, input int c);
    logic [11:0] r;
    r = (s == SRC_VREF) ? req[6] : (s == SRC_PIN) ? req[2*c+1] :
      (s == SRC_CONV0) ? req[4] : req[5];
    return req[2*c] > r;
  endfunction : want

  // enable and selector check, on the pins and in the status word
  task automatic run_cfg(input logic [31:0] c);
    bus(1, `CMP_CTRL_OFFSET, c);
    repeat (2) @(posedge pclk);
    chk1(r0, c[0] & want(c[2:1], 0));
    chk1(r1, c[4] & want(c[6:5], 1));
    chk1(pd0, ~c[0]);
    chk1(pd1, ~c[4]);
    bus(0, `CMP_STAT_OFFSET, 0);
    chk32(q, {30'h0, c[4] & want(c[6:5], 1),
      c[0] & want(c[2:1], 0)});
  endtask : run_cfg

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, fail_count, n_checks, cyc} = '0;
    req = {12'd110, 12'd120, 12'd90, 12'd130, 12'd115, 12'd80, 12'd100};
    presetn = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    chk1(pd0 & pd1, 1'b1);
    chk1(r0 | r1, 1'b0);
    bus(0, `CMP_CTRL_OFFSET, 0);
    chk32(q, `CMP_CTRL_RESET);
    // reserved bits never store
    bus(1, `CMP_CTRL_OFFSET, 32'hFFFF_FF88);
    bus(0, `CMP_CTRL_OFFSET, 0);
    chk32(q, 32'h0000_0000);
    bus(1, `CMP_CTRL_OFFSET, 32'hFFFF_FFFF);
    bus(0, `CMP_CTRL_OFFSET, 0);
    chk32(q, 32'h0000_0077);
    // status ignores writes, outside the two words is an error
    bus(1, `CMP_STAT_OFFSET, 32'h0000_0000);
    chk1(e, 1'b0);
    bus(0, `CMP_CTRL_OFFSET, 0);
    chk32(q, 32'h0000_0077);
    bus(1, 12'h00C, 32'h0000_0000);
    chk1(e, 1'b1);
    bus(0, 12'h008, 0);
    chk32(q, `CMP_ZERO_WORD);
    chk1(e, 1'b1);
    bus(0, `CMP_CTRL_OFFSET, 0);
    chk32(q, 32'h0000_0077);
    // every selector pair, both enabled
    for (int s = 0; s < 4; s++)
      for (int t = 0; t < 4; t++)
        run_cfg(32'(t) << 5 | 32'h10 | 32'(s) << 1 | 32'h1);
    // no enable, then each enable alone, with the input above its reference
    run_cfg(32'h0000_0002);
    run_cfg(32'h0000_0003);
    run_cfg(32'h0000_0012);
    // equal levels do not count as exceeding
    @(posedge pclk);
    req[0] <= 12'd110;
    repeat (5) @(posedge pclk);
    run_cfg(32'h0000_0001);
    @(posedge pclk);
    req[0] <= 12'd111;
    repeat (5) @(posedge pclk);
    run_cfg(32'h0000_0001);
    close_out();
  end
endmodule : tb_top

`default_nettype wire
